// ---- adc_channel_reset_power_control.sv ----
// Purpose: per-channel soft reset, shutdown, hard reset and full-shutdown control
// Assumes: config bits and sample data are synchronous to core_clk_i
// Assumes: every phase delay is at most the sample period, or that channel never ticks
// Notes: rst_i is the combined power-on / reset-pin hard reset
// Functional notes
// - soft-reset bit set: run, force output zero
// - soft reset returns quantizer field to 0011
// - independent soft reset, config untouched
// - no data-ready while in soft reset
// - leave soft reset keeping phase, realigned
// - partial soft reset keeps internal clock running
// - all soft reset gates core clock
// - all soft reset still clocks input bias
// - hard reset only from POR or pin
// - hard reset clears data, comparators, filters
// - serial interface held in hard reset
// - shutdown clear enables channel, ready after settling
// - shutdown per channel via its bit only
// - shutdown flushes data, no data-ready
// - leave shutdown keeping phase, realigned
// - all shutdown stops input and core clock
// - full shutdown disables analog, monitors, reference
// - serial interface stays active in full shutdown
// - any bit cleared re-enables supply monitors
// - analog biases stay on during hard reset
`timescale 1ns/1ns
module adc_channel_reset_power_control #(
  parameter int unsigned SETTLE_CYC = adc_rst_pwr_pkg::SETTLE_CYC_DEFAULT
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire adc_rst_pwr_pkg::cfg_bits_t cfg_i,
  input wire logic [adc_rst_pwr_pkg::PHASE_W-1:0] sample_period_i,
  input wire logic [adc_rst_pwr_pkg::PHASE_W-1:0] phase_delay_i [adc_rst_pwr_pkg::NUM_CH],
  input wire logic [adc_rst_pwr_pkg::DATA_W-1:0] conv_data_i [adc_rst_pwr_pkg::NUM_CH],
  input wire logic [adc_rst_pwr_pkg::QNT_W-1:0] quant_i [adc_rst_pwr_pkg::NUM_CH],
  output logic [adc_rst_pwr_pkg::DATA_W-1:0] ch_data_o [adc_rst_pwr_pkg::NUM_CH],
  output logic [adc_rst_pwr_pkg::QNT_W*adc_rst_pwr_pkg::NUM_CH-1:0] modulator_output_reg_o,
  output logic [adc_rst_pwr_pkg::NUM_CH-1:0] data_ready_o,
  output logic [adc_rst_pwr_pkg::NUM_CH-1:0] filter_clear_o,
  output logic [adc_rst_pwr_pkg::NUM_CH-1:0] ch_bias_en_o,
  output adc_rst_pwr_pkg::pwr_ctrl_t pwr_o,
  output logic serial_reset_o
);

  localparam int unsigned N = adc_rst_pwr_pkg::NUM_CH;
  localparam int unsigned QW = adc_rst_pwr_pkg::QNT_W;
  localparam logic [adc_rst_pwr_pkg::CNT_W-1:0] SETTLE_N =
    adc_rst_pwr_pkg::CNT_W'(SETTLE_CYC);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // a channel converts only when neither its reset nor its shutdown bit is set
  function automatic logic ch_active(input adc_rst_pwr_pkg::cfg_bits_t c, input int unsigned n);
    ch_active = !c.soft_reset[n] && !c.shutdown[n];
  endfunction : ch_active

  // reset and shutdown both park a channel: zero data, filters held clear
  function automatic logic ch_parked(input adc_rst_pwr_pkg::ch_state_t s);
    ch_parked = (s == adc_rst_pwr_pkg::CH_RST) || (s == adc_rst_pwr_pkg::CH_OFF);
  endfunction : ch_parked

  // ------------------------------------------------------------------
  // channel state and mode decode signals
  // ------------------------------------------------------------------
  adc_rst_pwr_pkg::ch_state_t st_r [N];
  adc_rst_pwr_pkg::ch_state_t st_nxt [N];
  logic [adc_rst_pwr_pkg::CNT_W-1:0] settle_r [N];
  logic [N-1:0] hit;
  logic [N-1:0] active;
  logic any_active;
  logic all_reset_or_off;
  logic all_shutdown;
  logic full_shutdown;
  logic timer_run;

  // ------------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------------
  // bit n of each field steers channel n only
  always_comb begin
    for (int unsigned i = 0; i < N; i++) begin
      active[i] = ch_active(cfg_i, i);
    end
  end

  // any live channel keeps the core clock and the shared tick going
  assign any_active = |active;
  assign all_shutdown = (cfg_i.shutdown == adc_rst_pwr_pkg::ALL_CH);
  assign all_reset_or_off = !any_active;
  // full power-down only with every shutdown bit and both external selects set
  assign full_shutdown = all_shutdown && cfg_i.external_ref_select
                         && cfg_i.external_clock_select;
  // tick keeps running while any channel converts, so phase is kept
  assign timer_run = any_active && !rst_i;

  // ------------------------------------------------------------------
  // per-channel phase timers
  // ------------------------------------------------------------------
  // identical counters, one comparator each against that channel's delay
  for (genvar g = 0; g < N; g++) begin : g_tmr
    adc_phase_timer #(
      .PHASE_W(adc_rst_pwr_pkg::PHASE_W)
    ) u_tmr (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .run_i(timer_run),
      .period_i(sample_period_i),
      .delay_i(phase_delay_i[g]),
      .hit_o(hit[g])
    );
  end

  // ------------------------------------------------------------------
  // channel state machine
  // ------------------------------------------------------------------
  // shutdown takes priority over soft reset since biases go off too
  always_comb begin
    for (int unsigned i = 0; i < N; i++) begin
      st_nxt[i] = st_r[i];
      case (st_r[i])
        adc_rst_pwr_pkg::CH_OFF: begin
          // waking rejoins the shared tick, so the old delay still holds
          if (!cfg_i.shutdown[i]) begin
            st_nxt[i] = cfg_i.soft_reset[i] ? adc_rst_pwr_pkg::CH_RST
                                            : adc_rst_pwr_pkg::CH_SETTLE;
          end
        end
        adc_rst_pwr_pkg::CH_RST: begin
          if (cfg_i.shutdown[i]) begin
            st_nxt[i] = adc_rst_pwr_pkg::CH_OFF;
          end else if (!cfg_i.soft_reset[i]) begin
            st_nxt[i] = adc_rst_pwr_pkg::CH_SETTLE;
          end
        end
        adc_rst_pwr_pkg::CH_SETTLE, adc_rst_pwr_pkg::CH_RUN: begin
          if (cfg_i.shutdown[i]) begin
            st_nxt[i] = adc_rst_pwr_pkg::CH_OFF;
          end else if (cfg_i.soft_reset[i]) begin
            st_nxt[i] = adc_rst_pwr_pkg::CH_RST;
          end else if (st_r[i] == adc_rst_pwr_pkg::CH_SETTLE && hit[i]
                       && settle_r[i] >= SETTLE_N) begin
            st_nxt[i] = adc_rst_pwr_pkg::CH_RUN;
          end
        end
        default: begin
          st_nxt[i] = adc_rst_pwr_pkg::CH_RST;
        end
      endcase
    end
  end

  // hard reset lands every channel in reset; registers take defaults
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int unsigned i = 0; i < N; i++) begin
        st_r[i] <= adc_rst_pwr_pkg::CH_RST;
      end
    end else begin
      for (int unsigned i = 0; i < N; i++) begin
        st_r[i] <= st_nxt[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // filter settling counter
  // ------------------------------------------------------------------
  // counts sample ticks after a release; the first ready waits for settling
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int unsigned i = 0; i < N; i++) begin
        settle_r[i] <= '0;
      end
    end else begin
      for (int unsigned i = 0; i < N; i++) begin
        if (st_r[i] != adc_rst_pwr_pkg::CH_SETTLE) begin
          settle_r[i] <= '0;
        end else if (hit[i] && settle_r[i] < SETTLE_N) begin
          // saturates so a long wait cannot wrap
          settle_r[i] <= settle_r[i] + 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // data-ready pulses
  // ------------------------------------------------------------------
  // one pulse per tick, and only from a channel that stays in or enters run
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_ready_o <= '0;
    end else begin
      for (int unsigned i = 0; i < N; i++) begin
        data_ready_o[i] <= (st_nxt[i] == adc_rst_pwr_pkg::CH_RUN) && hit[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // output data
  // ------------------------------------------------------------------
  // parked channels read zero; settling samples pass but are not flagged
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int unsigned i = 0; i < N; i++) begin
        ch_data_o[i] <= adc_rst_pwr_pkg::DATA_ZERO;
      end
    end else begin
      for (int unsigned i = 0; i < N; i++) begin
        if (ch_parked(st_r[i])) begin
          ch_data_o[i] <= adc_rst_pwr_pkg::DATA_ZERO;
        end else if (hit[i]) begin
          ch_data_o[i] <= conv_data_i[i];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // quantizer field of the modulator output register
  // ------------------------------------------------------------------
  // reset pattern is held while in soft reset or after hard reset
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int unsigned i = 0; i < N; i++) begin
        modulator_output_reg_o[i*QW +: QW] <= adc_rst_pwr_pkg::QNT_DEFAULT;
      end
    end else begin
      for (int unsigned i = 0; i < N; i++) begin
        if (st_r[i] == adc_rst_pwr_pkg::CH_RST || cfg_i.soft_reset[i]) begin
          modulator_output_reg_o[i*QW +: QW] <= adc_rst_pwr_pkg::QNT_DEFAULT;
        end else if (st_r[i] == adc_rst_pwr_pkg::CH_OFF) begin
          modulator_output_reg_o[i*QW +: QW] <= adc_rst_pwr_pkg::QNT_DEFAULT;
        end else begin
          // a live channel mirrors its comparators
          modulator_output_reg_o[i*QW +: QW] <= quant_i[i];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // filter clear
  // ------------------------------------------------------------------
  // filters and their output buffers are cleared by hard reset and idle modes
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      filter_clear_o <= '1;
    end else begin
      for (int unsigned i = 0; i < N; i++) begin
        filter_clear_o[i] <= ch_parked(st_nxt[i]);
      end
    end
  end

  // ------------------------------------------------------------------
  // channel biases
  // ------------------------------------------------------------------
  // biases follow the shutdown bit alone, so a soft reset costs no bias settling
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ch_bias_en_o <= '1;
    end else begin
      for (int unsigned i = 0; i < N; i++) begin
        ch_bias_en_o[i] <= !cfg_i.shutdown[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // chip-level clock and power enables
  // ------------------------------------------------------------------
  // config bits are only read here, never written, so settings survive
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_o.core_clk_en <= 1'b1;
      pwr_o.input_clk_en <= 1'b1;
      pwr_o.por_mon_en <= 1'b1;
      pwr_o.analog_en <= 1'b1;
      pwr_o.vref_en <= 1'b1;
      pwr_o.serial_en <= 1'b0;
    end else begin
      pwr_o.core_clk_en <= !all_reset_or_off;
      pwr_o.input_clk_en <= !all_shutdown;
      pwr_o.por_mon_en <= !full_shutdown;
      pwr_o.analog_en <= !full_shutdown;
      pwr_o.vref_en <= !full_shutdown;
      pwr_o.serial_en <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // serial port reset
  // ------------------------------------------------------------------
  // serial port is held in reset for the whole hard reset
  assign serial_reset_o = rst_i;

endmodule : adc_channel_reset_power_control

// ---- adc_rst_pwr_pkg.sv ----
// Purpose: shared constants and carrier types for the channel reset/power controller
// Assumes: three converter channels, one core clock
// Notes: all numbers used by the design live here
package adc_rst_pwr_pkg;

  // ------------------------------------------------------------------
  // sizes and defaults
  // ------------------------------------------------------------------
  localparam int unsigned NUM_CH = 3;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned QNT_W = 4;
  localparam logic [3:0] QNT_DEFAULT = 4'h3;     // thermometer reset pattern 0011
  localparam logic [2:0] ALL_CH = 3'h7;
  localparam logic [2:0] NO_CH = 3'h0;
  localparam logic [23:0] DATA_ZERO = 24'h000000;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SETTLE_CYC_DEFAULT = 16;   // filter settling, in decimated samples
  localparam int unsigned PHASE_W = 8;
  localparam int unsigned CNT_W = 16;

  // per-channel state
  typedef enum logic [3:0] {
    CH_OFF = 4'b0001,
    CH_RST = 4'b0010,
    CH_SETTLE = 4'b0100,
    CH_RUN = 4'b1000
  } ch_state_t;

  // control bits from the host's configuration words
  typedef struct packed {
    logic [2:0] soft_reset;
    logic [2:0] shutdown;
    logic external_ref_select;
    logic external_clock_select;
  } cfg_bits_t;

  // clock and power enables towards the rest of the chip
  typedef struct packed {
    logic core_clk_en;
    logic input_clk_en;
    logic por_mon_en;
    logic analog_en;
    logic vref_en;
    logic serial_en;
  } pwr_ctrl_t;

endpackage : adc_rst_pwr_pkg

// ---- adc_phase_timer.sv ----
// Purpose: common sample tick with per-channel phase offset
// Assumes: the tick counter only stops when every channel is idle
// Notes: channel strobe fires when the shared count matches its delay
`timescale 1ns/1ns
module adc_phase_timer #(
  parameter int unsigned PHASE_W = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [PHASE_W-1:0] period_i,
  input wire logic [PHASE_W-1:0] delay_i,
  output logic hit_o
);

  logic [PHASE_W-1:0] count_r;

  // ------------------------------------------------------------------
  // free counter, shared phase reference for all channels
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_r <= '0;
    end else if (!run_i) begin
      count_r <= '0;
    end else if (count_r >= period_i) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + 1'b1;
    end
  end

  // matching against the stored delay keeps relative phase after a release
  assign hit_o = run_i && (count_r == delay_i);

endmodule : adc_phase_timer

// ---- adc_rst_pwr_properties.sv ----
// Purpose: port-level checks for the channel reset/power controller
// Assumes: cfg held after a wake until the first data-ready of that channel
// Notes: bound to the top module by name
`timescale 1ns/1ns
module adc_rst_pwr_checker #(
  parameter int unsigned SETTLE_CYC = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire adc_rst_pwr_pkg::cfg_bits_t cfg_i,
  input wire logic [23:0] ch_data_o [3],
  input wire logic [11:0] modulator_output_reg_o,
  input wire logic [2:0] data_ready_o,
  input wire logic [2:0] filter_clear_o,
  input wire logic [2:0] ch_bias_en_o,
  input wire adc_rst_pwr_pkg::pwr_ctrl_t pwr_o,
  input wire logic serial_reset_o
);
  localparam int WAKE_MAX = 300;
  logic [2:0] idle;
  logic full;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ----
  // channel idle and full-shutdown decode
  // ----
  assign idle = cfg_i.soft_reset | cfg_i.shutdown;
  assign full = (&cfg_i.shutdown) & cfg_i.external_ref_select & cfg_i.external_clock_select;
  sequence s_ch0_wake;
    $fell(idle[0]) ##1 !idle[0];
  endsequence
  soft_zero_a: assert property (
    cfg_i.soft_reset[1] [*3] |-> ch_data_o[1] == 24'h000000) else $error("soft data not zero");
  quant_dflt_a: assert property (
    idle[1] [*3] |-> modulator_output_reg_o[7:4] == adc_rst_pwr_pkg::QNT_DEFAULT)
    else $error("quantizer field not default");
  no_ready_a: assert property (
    !$past(rst_i) |-> (data_ready_o & idle & $past(idle) & $past(idle, 2)) == 3'h0)
    else $error("data ready from idle channel");
  flush_zero_a: assert property (
    cfg_i.shutdown[2] [*3] |-> ch_data_o[2] == 24'h000000) else $error("shutdown data kept");
  core_gate_a: assert property (
    !$past(rst_i) |-> pwr_o.core_clk_en == !(&$past(idle))) else $error("core clock gate");
  input_clk_a: assert property (
    !$past(rst_i) |-> pwr_o.input_clk_en == !(&$past(cfg_i.shutdown)))
    else $error("input clock gate");
  full_off_a: assert property (
    $past(full) && !$past(rst_i) |-> !pwr_o.analog_en && !pwr_o.vref_en && !pwr_o.por_mon_en)
    else $error("full shutdown left power on");
  mon_back_a: assert property (
    !$past(full) && !$past(rst_i) |-> pwr_o.por_mon_en) else $error("monitor not enabled");
  serial_live_a: assert property (
    !$past(rst_i) |-> pwr_o.serial_en) else $error("serial not enabled");
  // the first reset edge is skipped: flops may not have seen the reset rise yet
  serial_hold_a: assert property (disable iff (1'b0)
    $past(rst_i) && rst_i |-> serial_reset_o && !pwr_o.serial_en)
    else $error("serial not held in reset");
  hard_clear_a: assert property (disable iff (1'b0)
    $past(rst_i) && rst_i |-> modulator_output_reg_o == 12'h333 && filter_clear_o == 3'h7
    && ch_bias_en_o == 3'h7 && pwr_o.analog_en) else $error("hard reset state wrong");
  bias_track_a: assert property (
    !$past(rst_i) |-> ch_bias_en_o == ~$past(cfg_i.shutdown)) else $error("bias enable wrong");
  // bound wait: woken channel 0 must report once settled
  wake_ready_a: assert property (
    s_ch0_wake |-> ##[0:WAKE_MAX] data_ready_o[0]) else $error("no ready after wake");
endmodule : adc_rst_pwr_checker

bind adc_channel_reset_power_control adc_rst_pwr_checker #(.SETTLE_CYC(SETTLE_CYC)) chk_i (
  .core_clk_i, .rst_i, .cfg_i, .ch_data_o, .modulator_output_reg_o, .data_ready_o,
  .filter_clear_o, .ch_bias_en_o, .pwr_o, .serial_reset_o);

// ---- host_cfg_model.sv ----
// Purpose: host side: reset pin and configuration bits
// Assumes: requests arrive from the bench on the core clock
// Notes: a short reset request is stretched to a valid width
`timescale 1ns/1ns
module host_cfg_model #(
  parameter int MIN_RST = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_req_i,
  input wire adc_rst_pwr_pkg::cfg_bits_t cfg_req_i,
  output logic rst_o,
  output adc_rst_pwr_pkg::cfg_bits_t cfg_o
);
  int low_cnt = 0;
  adc_rst_pwr_pkg::cfg_bits_t cfg_r = '0;
  // pin kept asserted for MIN_RST cycles past the request
  always_ff @(posedge core_clk_i) begin
    if (rst_req_i) low_cnt <= MIN_RST;
    else if (low_cnt != 0) low_cnt <= low_cnt - 1;
  end
  assign rst_o = rst_req_i || (low_cnt != 0);
  // no writes while the device is in hard reset; they would be lost
  always_ff @(posedge core_clk_i) begin
    if (!rst_o) cfg_r <= cfg_req_i;
  end
  assign cfg_o = cfg_r;
endmodule : host_cfg_model

// ---- tb.sv ----
// Purpose: directed tests of the channel reset/power controller
// Assumes: settling shortened to 2 ticks, tick every 8 cycles
// Notes: ready spacing follows the phase delays 1, 3, 5
`timescale 1ns/1ns
module tb;
  logic core_clk_i = 1'b0;
  logic rst_req = 1'b1;
  logic rst;
  adc_rst_pwr_pkg::cfg_bits_t cfg_req = '0;
  adc_rst_pwr_pkg::cfg_bits_t cfg;
  logic [7:0] dly [3] = '{8'h01, 8'h03, 8'h05};
  logic [23:0] din [3] = '{24'h1a2b3c, 24'h4d5e6f, 24'h778899};
  logic [3:0] qin [3] = '{4'hf, 4'hf, 4'hf};
  logic [23:0] dout [3];
  logic [11:0] modr;
  logic [2:0] rdy;
  logic [2:0] fclr;
  logic [2:0] bias;
  adc_rst_pwr_pkg::pwr_ctrl_t pwr;
  logic ser_rst;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int last_rdy [3] = '{0, 0, 0};
  host_cfg_model host (.core_clk_i(core_clk_i), .rst_req_i(rst_req), .cfg_req_i(cfg_req),
    .rst_o(rst), .cfg_o(cfg));
  adc_channel_reset_power_control #(.SETTLE_CYC(2)) dut (.core_clk_i(core_clk_i), .rst_i(rst),
    .cfg_i(cfg), .sample_period_i(8'h07), .phase_delay_i(dly), .conv_data_i(din),
    .quant_i(qin), .ch_data_o(dout), .modulator_output_reg_o(modr), .data_ready_o(rdy),
    .filter_clear_o(fclr), .ch_bias_en_o(bias), .pwr_o(pwr), .serial_reset_o(ser_rst));
  initial forever #2 core_clk_i = ~core_clk_i;
  // cycle stamp of each channel's latest data-ready pulse
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    for (int n = 0; n < 3; n++) if (rdy[n] === 1'b1) last_rdy[n] <= cyc;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : step
  task automatic set_cfg(input logic [7:0] v);
    @(posedge core_clk_i);
    cfg_req <= v;
    step(3);
  endtask : set_cfg
  // bounded wait so a silent channel cannot hang the run
  task automatic wait_rdy(input int n);
    int k = 0;
    while (rdy[n] !== 1'b1 && k < 200) begin
      step(1);
      k++;
    end
    chk(24'(k < 200), 24'h1);
    step(1);
  endtask : wait_rdy
  task automatic t_hard();
    chk(24'(modr), 24'h333);
    chk(24'({fclr, ser_rst}), 24'hf);
    chk(24'({bias, pwr.analog_en}), 24'hf);
    chk(dout[1], 24'h0);
    $display("test hard reset done");
  endtask : t_hard
  task automatic t_soft();
    int t0;
    set_cfg(8'h40);
    step(20);
    chk(dout[1], 24'h0);
    chk(24'(modr[7:4]), 24'h3);
    chk(dout[0], din[0]);
    chk(24'({fclr, modr[3:0]}), 24'h2f);
    t0 = cyc;
    step(16);
    chk(24'(last_rdy[1] < t0), 24'h1);
    chk(24'({last_rdy[0] >= t0, pwr.core_clk_en}), 24'h3);
    set_cfg(8'h00);
    wait_rdy(1);
    chk(24'(last_rdy[1] - last_rdy[0]), 24'h2);
    chk(24'({fclr, modr[7:4]}), 24'h0f);
    $display("test soft reset done");
  endtask : t_soft
  task automatic t_allsoft();
    set_cfg(8'he0);
    chk(24'(pwr), 24'h1f);
    set_cfg(8'hc0);
    chk(24'(pwr), 24'h3f);
    wait_rdy(0);
    set_cfg(8'h00);
    wait_rdy(1);
    $display("test all soft reset done");
  endtask : t_allsoft
  task automatic t_shut();
    int t0;
    set_cfg(8'h10);
    step(20);
    chk(dout[2], 24'h0);
    chk(24'(bias), 24'h3);
    t0 = cyc;
    step(16);
    chk(24'(last_rdy[2] < t0), 24'h1);
    set_cfg(8'h00);
    // early samples after wake are not judged, bias may still be settling
    wait_rdy(2);
    chk(24'(last_rdy[2] - last_rdy[0]), 24'h4);
    $display("test shutdown done");
  endtask : t_shut
  task automatic t_full();
    set_cfg(8'h1f);
    chk(24'(pwr), 24'h01);
    chk(24'({fclr, modr}), 24'h7333);
    set_cfg(8'h1e);
    chk(24'(pwr), 24'h0f);
    set_cfg(8'h00);
    wait_rdy(0);
    $display("test full shutdown done");
  endtask : t_full
  // short pin pulse in mid-run; the host stretches it to a valid width
  task automatic t_rerst();
    @(posedge core_clk_i);
    rst_req <= 1'b1;
    @(posedge core_clk_i);
    rst_req <= 1'b0;
    step(2);
    t_hard();
    wait_rdy(0);
    $display("test mid-run reset done");
  endtask : t_rerst
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    step(5000);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    step(10);
    t_hard();
    repeat (10) @(posedge core_clk_i);
    rst_req <= 1'b0;
    wait_rdy(0);
    chk(dout[0], din[0]);
    t_soft();
    t_allsoft();
    t_shut();
    t_full();
    t_rerst();
    tally_and_finish();
  end
endmodule : tb
